/* logic/interp_pkg.sv */
// Purpose: constants and types shared by the unsigned interpolate datapath
// Assumes: 32-bit Avalon-MM register bus, byte addresses, one word each
// Notes: register offsets are byte addresses on the slave port
package interp_pkg;
    // register map
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_OPWORD = 8'h04;
    localparam logic [7:0] OFS_DEST = 8'h08;
    localparam logic [7:0] OFS_SRC_M = 8'h0C;
    localparam logic [7:0] OFS_SRC_N = 8'h10;
    localparam logic [7:0] OFS_EA = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_FLAGS = 8'h1C;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h20;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
    // field positions
    localparam int CTRL_START_BIT = 0;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_ILLEGAL_BIT = 1;
    localparam int FLAG_X = 4;
    localparam int FLAG_N = 3;
    localparam int FLAG_Z = 2;
    localparam int FLAG_V = 1;
    localparam int FLAG_C = 0;
    // reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [4:0] RST_FLAGS = 5'h00;
    localparam logic [1:0] RST_IRQ = 2'h0;
    // instruction encoding
    localparam logic [9:0] OP_FIXED = 10'h3E0;
    localparam logic [1:0] MODE_TABLE = 2'h1;
    localparam logic [1:0] MODE_REG = 2'h0;
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_WORD = 2'h1;
    localparam logic [1:0] SIZE_LONG = 2'h2;
    localparam logic [2:0] EA_IND = 3'h2;
    localparam logic [2:0] EA_DISP = 3'h5;
    localparam logic [2:0] EA_INDEX = 3'h6;
    localparam logic [2:0] EA_EXT = 3'h7;
    localparam logic [2:0] EA_EXT_MAX_REG = 3'h3;
    localparam logic [39:0] HALF_LSB = 40'h00_0000_0080;
    // sequencer states
    typedef enum logic [1:0] {
        S_IDLE,
        S_RD_N,
        S_RD_N1,
        S_CALC
    } seq_t;
endpackage

/* logic/unsigned_table_interpolate.sv */
// Purpose: unsigned table lookup / register interpolate execution datapath
// Assumes: sequencer loads operands over Avalon-MM, memory answers reads
// Notes: one interpolation at a time; busy blocks operand writes
//
// Overview of operation
// RULE_01 - two modes: table lookup from memory, or two data registers
// RULE_02 - table mode: destination low 16 bits are 8.8 independent variable
// RULE_03 - entry n at address plus integer byte times size; then n+1
// RULE_04 - result is entry n plus difference times fraction
// RULE_05 - register mode: sources are entries, only fraction byte used
// RULE_06 - entries are unsigned, width 8, 16 or 32 by size
// RULE_07 - unrounded results are zero-extended to 32 bits
// RULE_08 - round bit zero: add one when discarded fraction is half or more
// RULE_09 - rounded result writes only the bits of the chosen size
// RULE_10 - unrounded integer part lands at 15:8, 23:8 or 31:8
// RULE_11 - unrounded fraction always lands in the lowest byte
// RULE_12 - extend kept, negative from msb, zero on zero, carry cleared
// RULE_13 - overflow when unrounded long integer leaves signed 24-bit range
// RULE_14 - table mode decoded from fixed two-word encoding
// RULE_15 - software keeps tables within 257 entries
// RULE_16 - resolution one 256th of entry spacing
// RULE_17 - size field 00 byte, 01 word, 10 long
// RULE_18 - zero address mode selects register variant, else source zero
// RULE_19 - table mode accepts only control addressing modes
`timescale 1ns/1ps
module unsigned_table_interpolate (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    output logic mem_read,
    output logic [31:0] mem_address,
    output logic [1:0] mem_size,
    input wire logic [31:0] mem_readdata,
    input wire logic mem_valid
);

    typedef struct packed {
        interp_pkg::seq_t seq;
        logic waitreq;
        logic [31:0] readdata;
        logic irq;
        logic [31:0] opword;
        logic [31:0] dest;
        logic [31:0] src_m;
        logic [31:0] src_n;
        logic [31:0] ea;
        logic [4:0] flags;
        logic [1:0] irq_status;
        logic [1:0] irq_mask;
        logic [31:0] entry_n;
        logic [31:0] entry_n1;
        logic mem_read;
        logic [31:0] mem_addr;
    } state_t;

    state_t cur;
    state_t nxt;

    logic [31:0] be_mask;
    logic accept;
    logic wr_acc;
    logic rd_acc;
    logic [15:0] w1;
    logic [15:0] w2;
    logic [2:0] ea_mode;
    logic [2:0] ea_reg;
    logic [1:0] size;
    logic round_off;
    logic ea_ok;
    logic enc_ok;
    logic reg_mode;
    logic [31:0] ent_n;
    logic [31:0] ent_n1;
    logic signed [32:0] diff;
    logic signed [41:0] prod;
    logic [39:0] full;
    logic [39:0] full_rnd;
    logic [31:0] rnd;
    logic [31:0] result;
    logic res_msb;
    logic res_zero;
    logic ovf;
    logic [31:0] scaled_idx;
    logic [31:0] step;
    logic [1:0] irq_set;
    logic [31:0] rd_mux;

    // byte-lane write mask from the byte enables
    generate
        for (genvar i = 0; i < 4; i++) begin : g_be
            assign be_mask[8*i +: 8] = {8{avs_byteenable[i]}};
        end
    endgenerate

    // bus handshake: answer one cycle after the request appears
    assign accept = (avs_read || avs_write) && !cur.waitreq;
    assign wr_acc = accept && avs_write;
    assign rd_acc = accept && avs_read;

    // instruction field split
    assign w1 = cur.opword[31:16];
    assign w2 = cur.opword[15:0];
    assign ea_mode = w1[5:3];
    assign ea_reg = w1[2:0];
    assign size = w2[7:6];
    assign round_off = w2[10];
    assign reg_mode = (ea_mode == 3'h0); // RULE_18

    // control addressing modes only
    always_comb begin
        unique case (ea_mode)
            interp_pkg::EA_IND: ea_ok = 1'b1; // RULE_19
            interp_pkg::EA_DISP: ea_ok = 1'b1; // RULE_19
            interp_pkg::EA_INDEX: ea_ok = 1'b1; // RULE_19
            interp_pkg::EA_EXT: ea_ok = (ea_reg <= interp_pkg::EA_EXT_MAX_REG);
            default: ea_ok = 1'b0;
        endcase
    end

    // full two-word encoding check for both variants
    always_comb begin
        enc_ok = (w1[15:6] == interp_pkg::OP_FIXED) // RULE_14
            && !w2[15] && !w2[11] && (w2[5:3] == 3'h0)
            && (size != 2'h3); // RULE_17
        if (reg_mode) begin
            enc_ok = enc_ok && (w2[9:8] == interp_pkg::MODE_REG); // RULE_18
        end else begin
            enc_ok = enc_ok && ea_ok
                && (w2[9:8] == interp_pkg::MODE_TABLE) // RULE_14
                && (w2[2:0] == 3'h0); // RULE_18
        end
    end

    // entries trimmed to unsigned values of the operand size
    always_comb begin
        unique case (size)
            interp_pkg::SIZE_BYTE: begin
                ent_n = {24'h0, cur.entry_n[7:0]}; // RULE_06
                ent_n1 = {24'h0, cur.entry_n1[7:0]};
                step = 32'h0000_0001;
            end
            interp_pkg::SIZE_WORD: begin
                ent_n = {16'h0, cur.entry_n[15:0]}; // RULE_06
                ent_n1 = {16'h0, cur.entry_n1[15:0]};
                step = 32'h0000_0002;
            end
            default: begin
                ent_n = cur.entry_n; // RULE_06
                ent_n1 = cur.entry_n1;
                step = 32'h0000_0004;
            end
        endcase
    end

    // table index scaled by operand size in bytes
    always_comb begin
        unique case (size)
            interp_pkg::SIZE_BYTE: scaled_idx = {24'h0, cur.dest[15:8]};
            interp_pkg::SIZE_WORD: scaled_idx = {23'h0, cur.dest[15:8], 1'b0};
            default: scaled_idx = {22'h0, cur.dest[15:8], 2'b0}; // RULE_03
        endcase
    end

    // interpolation: entry*256 + (n1 - n) * fraction, in 1/256 steps
    assign diff = $signed({1'b0, ent_n1}) - $signed({1'b0, ent_n}); // RULE_04
    assign prod = diff * $signed({1'b0, cur.dest[7:0]}); // RULE_16
    assign full = 40'({ent_n, 8'h00} + 40'(prod)); // RULE_04
    assign full_rnd = full + interp_pkg::HALF_LSB; // RULE_08
    assign rnd = full_rnd[39:8];

    // place result by size and rounding choice
    always_comb begin
        result = cur.dest;
        res_msb = 1'b0;
        res_zero = 1'b0;
        ovf = 1'b0;
        if (!round_off) begin
            unique case (size)
                interp_pkg::SIZE_BYTE: begin
                    result = {cur.dest[31:8], rnd[7:0]}; // RULE_09
                    res_msb = rnd[7];
                    res_zero = (rnd[7:0] == 8'h00);
                end
                interp_pkg::SIZE_WORD: begin
                    result = {cur.dest[31:16], rnd[15:0]}; // RULE_09
                    res_msb = rnd[15];
                    res_zero = (rnd[15:0] == 16'h0000);
                end
                default: begin
                    result = rnd; // RULE_09
                    res_msb = rnd[31];
                    res_zero = (rnd == 32'h0);
                end
            endcase
        end else begin
            unique case (size)
                interp_pkg::SIZE_BYTE: begin
                    result = {16'h0, full[15:0]}; // RULE_07 RULE_10 RULE_11
                    res_msb = full[15];
                    res_zero = (full[15:0] == 16'h0000);
                end
                interp_pkg::SIZE_WORD: begin
                    result = {8'h0, full[23:0]}; // RULE_07 RULE_10 RULE_11
                    res_msb = full[23];
                    res_zero = (full[23:0] == 24'h0);
                end
                default: begin
                    result = full[31:0]; // RULE_10 RULE_11
                    res_msb = full[31];
                    res_zero = (full[31:0] == 32'h0);
                    ovf = |full[39:31]; // RULE_13
                end
            endcase
        end
    end

    // register read mux; unmapped offsets read zero
    always_comb begin
        unique case (avs_address)
            interp_pkg::OFS_OPWORD: rd_mux = cur.opword;
            interp_pkg::OFS_DEST: rd_mux = cur.dest;
            interp_pkg::OFS_SRC_M: rd_mux = cur.src_m;
            interp_pkg::OFS_SRC_N: rd_mux = cur.src_n;
            interp_pkg::OFS_EA: rd_mux = cur.ea;
            interp_pkg::OFS_STATUS: rd_mux = {31'h0, cur.seq != interp_pkg::S_IDLE};
            interp_pkg::OFS_FLAGS: rd_mux = {27'h0, cur.flags};
            interp_pkg::OFS_IRQ_STATUS: rd_mux = {30'h0, cur.irq_status};
            interp_pkg::OFS_IRQ_MASK: rd_mux = {30'h0, cur.irq_mask};
            default: rd_mux = 32'h0;
        endcase
    end

    // next-state logic for bus, registers and sequencer
    always_comb begin
        nxt = cur;
        irq_set = 2'h0;
        nxt.waitreq = !((avs_read || avs_write) && cur.waitreq);
        if (rd_acc) begin
            nxt.readdata = 32'h0;
        end
        if ((avs_read || avs_write) && cur.waitreq) begin
            nxt.readdata = avs_read ? rd_mux : 32'h0;
        end
        // software writes while idle
        if (wr_acc && cur.seq == interp_pkg::S_IDLE) begin
            unique case (avs_address)
                interp_pkg::OFS_OPWORD:
                    nxt.opword = (cur.opword & ~be_mask) | (avs_writedata & be_mask);
                interp_pkg::OFS_DEST:
                    nxt.dest = (cur.dest & ~be_mask) | (avs_writedata & be_mask);
                interp_pkg::OFS_SRC_M:
                    nxt.src_m = (cur.src_m & ~be_mask) | (avs_writedata & be_mask);
                interp_pkg::OFS_SRC_N:
                    nxt.src_n = (cur.src_n & ~be_mask) | (avs_writedata & be_mask);
                interp_pkg::OFS_EA:
                    nxt.ea = (cur.ea & ~be_mask) | (avs_writedata & be_mask);
                interp_pkg::OFS_FLAGS:
                    if (avs_byteenable[0]) begin
                        nxt.flags = avs_writedata[4:0];
                    end
                default: ;
            endcase
        end
        if (wr_acc && avs_address == interp_pkg::OFS_IRQ_MASK && avs_byteenable[0]) begin
            nxt.irq_mask = avs_writedata[1:0];
        end
        if (wr_acc && avs_address == interp_pkg::OFS_IRQ_STATUS && avs_byteenable[0]) begin
            nxt.irq_status = cur.irq_status & ~avs_writedata[1:0];
        end
        // sequencer
        unique case (cur.seq)
            interp_pkg::S_IDLE: begin
                if (wr_acc && avs_address == interp_pkg::OFS_CTRL
                        && avs_byteenable[0]
                        && avs_writedata[interp_pkg::CTRL_START_BIT]) begin
                    if (!enc_ok) begin
                        irq_set[interp_pkg::IRQ_ILLEGAL_BIT] = 1'b1;
                    end else if (reg_mode) begin
                        nxt.entry_n = cur.src_m; // RULE_05 RULE_01
                        nxt.entry_n1 = cur.src_n; // RULE_05
                        nxt.seq = interp_pkg::S_CALC;
                    end else begin
                        nxt.mem_addr = cur.ea + scaled_idx; // RULE_03 RULE_02
                        nxt.mem_read = 1'b1; // RULE_01
                        nxt.seq = interp_pkg::S_RD_N;
                    end
                end
            end
            interp_pkg::S_RD_N: begin
                if (mem_valid) begin
                    nxt.entry_n = mem_readdata;
                    nxt.mem_addr = cur.mem_addr + step; // RULE_03
                    nxt.seq = interp_pkg::S_RD_N1;
                end
            end
            interp_pkg::S_RD_N1: begin
                if (mem_valid) begin
                    nxt.entry_n1 = mem_readdata;
                    nxt.mem_read = 1'b0;
                    nxt.seq = interp_pkg::S_CALC;
                end
            end
            interp_pkg::S_CALC: begin
                nxt.dest = result;
                nxt.flags[interp_pkg::FLAG_N] = res_msb; // RULE_12
                nxt.flags[interp_pkg::FLAG_Z] = res_zero; // RULE_12
                nxt.flags[interp_pkg::FLAG_V] = ovf; // RULE_13
                nxt.flags[interp_pkg::FLAG_C] = 1'b0; // RULE_12
                irq_set[interp_pkg::IRQ_DONE_BIT] = 1'b1;
                nxt.seq = interp_pkg::S_IDLE;
            end
        endcase
        // set wins over a clear in the same cycle
        nxt.irq_status = nxt.irq_status | irq_set;
        nxt.irq = |(nxt.irq_status & nxt.irq_mask);
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cur.seq <= interp_pkg::S_IDLE;
            cur.waitreq <= 1'b1;
            cur.readdata <= interp_pkg::RST_WORD;
            cur.irq <= 1'b0;
            cur.opword <= interp_pkg::RST_WORD;
            cur.dest <= interp_pkg::RST_WORD;
            cur.src_m <= interp_pkg::RST_WORD;
            cur.src_n <= interp_pkg::RST_WORD;
            cur.ea <= interp_pkg::RST_WORD;
            cur.flags <= interp_pkg::RST_FLAGS;
            cur.irq_status <= interp_pkg::RST_IRQ;
            cur.irq_mask <= interp_pkg::RST_IRQ;
            cur.entry_n <= interp_pkg::RST_WORD;
            cur.entry_n1 <= interp_pkg::RST_WORD;
            cur.mem_read <= 1'b0;
            cur.mem_addr <= interp_pkg::RST_WORD;
        end else begin
            cur <= nxt;
        end
    end

    // outputs straight from the state register
    assign avs_readdata = cur.readdata;
    assign avs_waitrequest = cur.waitreq;
    assign irq = cur.irq;
    assign mem_read = cur.mem_read;
    assign mem_address = cur.mem_addr;
    assign mem_size = cur.opword[7:6];

endmodule

/* verif/unsigned_table_interpolate_asserts.sv */
// Purpose: port checks for the interpolate datapath
// Assumes: one clock, synchronous active high reset
// Notes: bound to every instance of the datapath
`timescale 1ns/1ps
module unsigned_table_interpolate_asserts (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic mem_read,
    input wire logic [31:0] mem_address,
    input wire logic [1:0] mem_size,
    input wire logic mem_valid
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    logic [1:0] nval;
    logic [31:0] step;
    logic req;
    // entries answered in the current fetch
    always_ff @(posedge sys_clk) begin
        if (reset || !mem_read) begin
            nval <= 2'h0;
        end else if (mem_valid) begin
            nval <= nval + 2'h1;
        end
    end
    // entry spacing in bytes and any bus request
    assign step = 32'h1 << mem_size;
    assign req = avs_read || avs_write;
    chk_wait_short: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("wait low for more than one cycle");
    chk_wait_answer: assert property
        (req && avs_waitrequest && !$past(req) |=> !avs_waitrequest)
        else $error("access not answered in one cycle");
    chk_idle_wait: assert property (!req |=> avs_waitrequest)
        else $error("wait low without a request");
    chk_addr_step: assert property (mem_read && $past(mem_read) &&
        $changed(mem_address) |-> mem_address == $past(mem_address) + step)
        else $error("second entry not one entry after first");
    chk_addr_hold: assert property (mem_read && !mem_valid
        |=> !mem_read || $stable(mem_address))
        else $error("fetch address moved while waiting");
    chk_fetch_pair: assert property
        (mem_read && mem_valid && nval == 2'h1 |=> !mem_read)
        else $error("fetch kept going after two entries");
    chk_fetch_more: assert property
        (mem_read && mem_valid && nval == 2'h0 |=> mem_read)
        else $error("fetch ended after one entry");
    chk_size_code: assert property (mem_read |-> mem_size != 2'h3)
        else $error("fetch with reserved size code");
endmodule
bind unsigned_table_interpolate unsigned_table_interpolate_asserts chk (
    .sys_clk(sys_clk), .reset(reset), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
    .mem_read(mem_read), .mem_address(mem_address),
    .mem_size(mem_size), .mem_valid(mem_valid));

/* verif/interp_operand_mem.sv */
// Purpose: operand memory answering table entry fetches
// Assumes: one fetch at a time, entries returned as 32-bit words
// Notes: wait set by the bench; data line held while counting the wait, inverted when not valid otherwise
`timescale 1ns/1ps
module interp_operand_mem (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic mem_read,
    input wire logic [31:0] mem_address,
    input wire logic [3:0] wait_cycles,
    output logic [31:0] mem_readdata,
    output logic mem_valid
);
    logic [3:0] cnt;
    // table contents as a fixed scramble of the byte address
    function automatic logic [31:0] entry_at(input logic [31:0] a);
        return {a[10:3], 8'hC3 ^ a[9:2], a[7:0] ^ a[15:8], a[7:0] * 8'h1D};
    endfunction
    // one pulse per entry after the wait, data held while counting the wait, inverted otherwise
    always_ff @(posedge sys_clk) begin
        mem_valid <= 1'b0;
        if (reset) begin
            cnt <= 4'h0;
            mem_readdata <= 32'h5A5A_A5A5;
        end else if (mem_read && !mem_valid && cnt >= wait_cycles) begin
            mem_valid <= 1'b1;
            mem_readdata <= entry_at(mem_address);
            cnt <= 4'h0;
        end else if (mem_read && !mem_valid) begin
            cnt <= cnt + 4'h1;
        end else begin
            mem_readdata <= ~mem_readdata;
        end
    end
endmodule

/* verif/unsigned_table_interpolate_tb.sv */
// Purpose: self-checking bench of the interpolate datapath
// Assumes: operand memory model on the fetch port, checker bound
// Notes: random operations with corner fractions and bad encodings
`timescale 1ns/1ps
module unsigned_table_interpolate_tb;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'hF;
    logic [3:0] wait_cycles = 4'h0;
    logic [31:0] avs_readdata, mem_address, mem_readdata, q;
    logic avs_waitrequest, irq, mem_read, mem_valid;
    logic [1:0] mem_size;
    int n_mismatch = 0;
    int num_checks = 0;
    // 200 MHz clock
    always #2.5 sys_clk = ~sys_clk;
    unsigned_table_interpolate uut (.sys_clk(sys_clk), .reset(reset),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq),
        .mem_read(mem_read), .mem_address(mem_address),
        .mem_size(mem_size), .mem_readdata(mem_readdata),
        .mem_valid(mem_valid));
    interp_operand_mem mem (.sys_clk(sys_clk), .reset(reset),
        .mem_read(mem_read), .mem_address(mem_address),
        .wait_cycles(wait_cycles), .mem_readdata(mem_readdata),
        .mem_valid(mem_valid));
    // comparison and verdict
    task automatic check(input string what, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // one register access, held until wait drops
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, input logic [3:0] be);
        int i;
        @(posedge sys_clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        avs_byteenable <= be;
        i = 0;
        do begin
            @(posedge sys_clk);
            i++;
        end while (avs_waitrequest !== 1'b0 && i < 40);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 4'hF);
    endtask
    task automatic rd(input logic [7:0] a);
        xfer(1'b0, a, 32'h0, 4'hF);
    endtask
    // expected destination and flags of one operation
    function automatic logic [31:0] predict(input logic [1:0] sz,
        input logic r, input logic [31:0] d, a, b, input logic x,
        output logic [4:0] fl);
        logic [41:0] f, g;
        logic [31:0] v, w;
        f = {10'h0, a} * 42'h100 + ({10'h0, b} - {10'h0, a}) * d[7:0];
        g = r ? f : (f + 42'h80) >> 8;
        v = sz == 2'h2 ? g[31:0] : sz == 2'h1 ?
            (r ? {8'h0, g[23:0]} : {d[31:16], g[15:0]}) :
            (r ? {16'h0, g[15:0]} : {d[31:8], g[7:0]});
        w = sz == 2'h2 ? 32'hFFFF_FFFF : (32'h100 << (8 * (sz + r))) - 1;
        fl = {x, |(v & w & ~(w >> 1)), (v & w) == 0,
              r && sz == 2'h2 && f[41:31] != 0, 1'b0};
        return v;
    endfunction
    // load operands, start, wait for idle and check the outcome
    task automatic run(input logic [31:0] op, dst, m, n, ea,
                       input logic ill);
        logic [31:0] a, b, ex, msk;
        logic [4:0] fl;
        logic [1:0] mk;
        logic x;
        int k, by;
        by = 1 << op[7:6];
        msk = (32'h1 << (8 << op[7:6])) - 32'h1;
        a = op[8] ? mem.entry_at(ea + dst[15:8] * by) : m;
        b = op[8] ? mem.entry_at(ea + (dst[15:8] + 1) * by) : n;
        x = 1'($urandom_range(1, 0));
        mk = 2'($urandom_range(3, 0));
        ex = predict(op[7:6], op[10], dst, a & msk, b & msk, x, fl);
        wr(interp_pkg::OFS_SRC_M, m);
        wr(interp_pkg::OFS_SRC_N, n);
        wr(interp_pkg::OFS_EA, ea);
        wr(interp_pkg::OFS_DEST, dst);
        wr(interp_pkg::OFS_FLAGS, {27'h0, x, 4'hF});
        wr(interp_pkg::OFS_OPWORD, op);
        wr(interp_pkg::OFS_IRQ_MASK, {30'h0, mk});
        wr(interp_pkg::OFS_CTRL, 32'h1);
        if (op[8] && !ill) begin
            wr(interp_pkg::OFS_DEST, ~dst);
        end
        k = 0;
        do begin
            rd(interp_pkg::OFS_STATUS);
            k++;
        end while (q[0] !== 1'b0 && k < 40);
        if (q[0] !== 1'b0) begin
            n_mismatch++;
            tally_and_finish();
        end
        rd(interp_pkg::OFS_DEST);
        check("dest", q, ill ? dst : ex);
        rd(interp_pkg::OFS_FLAGS);
        check("flags", q, ill ? {27'h0, x, 4'hF} : {27'h0, fl});
        rd(interp_pkg::OFS_IRQ_STATUS);
        check("irq_status", q, ill ? 32'h2 : 32'h1);
        check("irq", {31'h0, irq}, {31'h0, |(q[1:0] & mk)});
        wr(interp_pkg::OFS_IRQ_STATUS, 32'h3);
        rd(interp_pkg::OFS_IRQ_STATUS);
        check("irq_clear", {q[30:0], irq}, 32'h0);
    endtask
    // main sequence
    initial begin
        logic [31:0] op, dst;
        static logic [2:0] eam [4] = '{3'h2, 3'h5, 3'h6, 3'h7};
        static logic [31:0] bad [7] = '{32'hF83C_1100, 32'hF80A_1100,
            32'hF811_1900, 32'hF811_11C0, 32'hF800_1100,
            32'hF851_1100, 32'hF811_1105};
        logic [2:0] md;
        op = $urandom(32'h3B22EDD3);
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        check("irq_reset", {31'h0, irq}, 32'h0);
        for (int i = 0; i < 11; i++) begin
            rd(8'(i * 4));
            check("reset_value", q, 32'h0);
        end
        wr(interp_pkg::OFS_DEST, 32'hFFFF_FFFF);
        xfer(1'b1, interp_pkg::OFS_DEST, 32'h1234_5678, 4'h1);
        rd(interp_pkg::OFS_DEST);
        check("byte_lane", q, 32'hFFFF_FF78);
        wr(8'h30, 32'hFFFF_FFFF);
        rd(8'h30);
        check("unmapped", q, 32'h0);
        for (int i = 0; i < 48; i++) begin
            md = eam[$urandom_range(3, 0)];
            dst = $urandom();
            if (i % 8 > 5) begin
                dst[7:0] = 8'h80;
            end
            wait_cycles <= 4'($urandom_range(3, 0));
            op = {10'h3E0, i[0] ? md : 3'h0,
                  md == 3'h7 ? 3'($urandom_range(3, 0)) : 3'($urandom),
                  1'b0, 3'($urandom), 1'b0, i[1], 1'b0, i[0],
                  2'(i / 4 % 3), 3'h0, i[0] ? 3'h0 : 3'($urandom)};
            run(op, dst, i == 4 ? 32'h0 : i == 10 ? 32'h007F_FFFF :
                $urandom(), i == 4 ? 32'h0 : i == 10 ? 32'h007F_FF00 :
                $urandom(), $urandom(), 1'b0);
        end
        for (int i = 0; i < 7; i++) begin
            run(bad[i], $urandom(), $urandom(), $urandom(), $urandom(),
                1'b1);
        end
        tally_and_finish();
    end
endmodule
